//--- logic/psw_pkg.sv
/*
 * psw_pkg: constants for the status word flag block (register map, bit positions,
 * reset values, bank base addresses, arithmetic operation classes).
 * assumes: used by psw_status_word and its bench; nothing is imported, every use is scoped.
 */
package psw_pkg;
    // ******************************************************************
    // register map (byte addresses on the ahb-lite slave)
    // ******************************************************************
    localparam logic [7:0]  ADDR_STATUS_WORD = 8'h00;   // program_status_word
    localparam logic [7:0]  ADDR_ACCUM       = 8'h04;   // accumulator mirror, read only
    localparam logic [7:0]  ADDR_BANK_BASE   = 8'h08;   // active bank base, read only
    localparam int          ADDR_LSB         = 2;
    localparam int          ADDR_BITS        = 8;

    // ******************************************************************
    // bit positions in the status word
    // ******************************************************************
    localparam int BIT_NIBBLE_CARRY = 6;
    localparam int BIT_USER_A       = 5;
    localparam int BIT_BANK_HI      = 4;
    localparam int BIT_BANK_LO      = 3;
    localparam int BIT_ARITH_EXCESS = 2;
    localparam int BIT_USER_B       = 1;
    localparam int BIT_PARITY       = 0;

    // ******************************************************************
    // reset values and bank mapping
    // ******************************************************************
    localparam logic        RST_FLAG      = 1'b0;
    localparam logic [1:0]  RST_BANK      = 2'h0;
    localparam logic [7:0]  RST_ACCUM     = 8'h00;
    localparam logic [7:0]  BANK_STRIDE   = 8'h08;      // eight registers per bank
    localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

    // ******************************************************************
    // arithmetic operation classes from the datapath
    // ******************************************************************
    typedef enum logic [1:0] {
        PSW_OP_ADD,
        PSW_OP_SUB,
        PSW_OP_MULDIV,
        PSW_OP_OTHER
    } psw_op_e;
endpackage : psw_pkg

//--- logic/psw_status_word.sv
/*
 * psw_status_word: status word flags of the cpu core, with user flags, register bank
 * select, arithmetic excess, nibble carry and parity, reachable over ahb-lite.
 * assumes: single clock hclk, asynchronous active-low hresetn, one ahb-lite master,
 * datapath strobes arith_valid and acc_load are one-cycle pulses synchronous to hclk.
 */
`timescale 1ns/1ps

// What this block does
// - two user flags at bits 5 and 1, changed only by software writes
// - bank select bits 4-3 choose register bank base 0x00, 0x08, 0x10 or 0x18
// - excess flag bit 2 set on add carry, subtract borrow, multiply/divide overflow
// - any arithmetic operation without that condition clears the excess flag
// - parity bit 0 is one when the accumulator has an odd count of ones
// - nibble carry bit 6 set on carry/borrow at upper nibble, else cleared
module psw_status_word #(
    parameter int ACC_WIDTH = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        arith_valid,
    input  wire logic [1:0]  arith_op,
    input  wire logic        arith_excess,
    input  wire logic        arith_nibble_carry,
    input  wire logic        acc_load,
    input  wire logic [7:0]  acc_value,
    input  wire logic [2:0]  reg_index,
    output logic      [4:0]  reg_addr,
    output logic      [1:0]  bank_select,
    output logic             arith_excess_flag,
    output logic             nibble_carry_flag,
    output logic             parity_flag,
    output logic             user_flag_a,
    output logic             user_flag_b
);
    // ******************************************************************
    // elaboration checks
    // ******************************************************************
    if (ACC_WIDTH != 8) begin : g_bad_width
        $error("psw_status_word: accumulator must be eight bits wide");
    end

    // odd count of ones in a byte
    function automatic logic odd_ones(input logic [7:0] v);
        odd_ones = ^v;
    endfunction : odd_ones

    // status word image from the flag registers
    function automatic logic [7:0] pack_word(input logic nc, input logic ua, input logic [1:0] bs,
                                             input logic ex, input logic ub, input logic par);
        logic [7:0] w;
        w = 8'h00;
        w[psw_pkg::BIT_NIBBLE_CARRY] = nc;
        w[psw_pkg::BIT_USER_A]       = ua;
        w[psw_pkg::BIT_BANK_HI]      = bs[1];
        w[psw_pkg::BIT_BANK_LO]      = bs[0];
        w[psw_pkg::BIT_ARITH_EXCESS] = ex;
        w[psw_pkg::BIT_USER_B]       = ub;
        w[psw_pkg::BIT_PARITY]       = par;
        pack_word = w;
    endfunction : pack_word

    // word-aligned register address from the bus address
    function automatic logic [7:0] word_addr(input logic [31:0] a);
        word_addr = {a[psw_pkg::ADDR_BITS-1:psw_pkg::ADDR_LSB], 2'b00};
    endfunction : word_addr

    // first register address of the selected bank
    function automatic logic [7:0] bank_base(input logic [1:0] bs);
        bank_base = 8'(bs) * psw_pkg::BANK_STRIDE;
    endfunction : bank_base

    // ******************************************************************
    // ahb-lite address phase capture
    // ******************************************************************
    logic                   wr_pend_q;
    logic [7:0]             addr_q;
    logic                   take;
    logic [7:0]             acc_q;
    logic [7:0]             word_now;
    logic                   sw_wr_word;

    // transfer taken on this edge, and the data phase of a status word write
    assign take       = hsel && hready && htrans[1];
    assign sw_wr_word = wr_pend_q && (addr_q == psw_pkg::ADDR_STATUS_WORD);
    assign word_now   = pack_word(nibble_carry_flag, user_flag_a, bank_select,
                                  arith_excess_flag, user_flag_b, parity_flag);

    // latch the transfer for its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite;
            if (take) begin
                addr_q <= word_addr(haddr);
            end
        end
    end

    // read data is registered at the address phase, zero-wait answers;
    // a read issued right behind a status word write returns the word
    // as it stood before that write lands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= psw_pkg::RDATA_ZERO;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (take && !hwrite) begin
                case (word_addr(haddr))
                    psw_pkg::ADDR_STATUS_WORD: hrdata <= {24'h00_0000, word_now};
                    psw_pkg::ADDR_ACCUM:       hrdata <= {24'h00_0000, acc_q};
                    psw_pkg::ADDR_BANK_BASE:   hrdata <= {24'h00_0000, bank_base(bank_select)};
                    default:                   hrdata <= psw_pkg::RDATA_ZERO;
                endcase
            end else begin
                hrdata <= psw_pkg::RDATA_ZERO;
            end
        end
    end

    // ******************************************************************
    // software-owned fields
    // ******************************************************************
    // user flags follow software writes only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            user_flag_a <= psw_pkg::RST_FLAG;
            user_flag_b <= psw_pkg::RST_FLAG;
        end else if (sw_wr_word) begin
            user_flag_a <= hwdata[psw_pkg::BIT_USER_A];
            user_flag_b <= hwdata[psw_pkg::BIT_USER_B];
        end
    end

    // bank select field
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_select <= psw_pkg::RST_BANK;
        end else if (sw_wr_word) begin
            bank_select <= {hwdata[psw_pkg::BIT_BANK_HI], hwdata[psw_pkg::BIT_BANK_LO]};
        end
    end

    // register operand address = bank base + index, registered;
    // a plain concatenation serves because every bank holds eight registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_addr <= 5'h00;
        end else begin
            reg_addr <= {bank_select, reg_index};
        end
    end

    // ******************************************************************
    // datapath-owned flags; hardware wins over a same-cycle software write
    // ******************************************************************
    // excess flag: the arithmetic result wins over a same-cycle software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arith_excess_flag <= psw_pkg::RST_FLAG;
        end else if (arith_valid) begin
            case (psw_pkg::psw_op_e'(arith_op))
                psw_pkg::PSW_OP_ADD,
                psw_pkg::PSW_OP_SUB,
                psw_pkg::PSW_OP_MULDIV: begin
                    arith_excess_flag <= arith_excess;
                end
                default: begin
                    arith_excess_flag <= 1'b0;
                end
            endcase
        end else if (sw_wr_word) begin
            arith_excess_flag <= hwdata[psw_pkg::BIT_ARITH_EXCESS];
        end
    end

    // nibble carry: only add and subtract carry across the nibble boundary
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nibble_carry_flag <= psw_pkg::RST_FLAG;
        end else if (arith_valid) begin
            case (psw_pkg::psw_op_e'(arith_op))
                psw_pkg::PSW_OP_ADD,
                psw_pkg::PSW_OP_SUB: begin
                    nibble_carry_flag <= arith_nibble_carry;
                end
                default: begin
                    nibble_carry_flag <= 1'b0;
                end
            endcase
        end else if (sw_wr_word) begin
            nibble_carry_flag <= hwdata[psw_pkg::BIT_NIBBLE_CARRY];
        end
    end

    // accumulator mirror and parity, updated together on every load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q       <= psw_pkg::RST_ACCUM;
            parity_flag <= psw_pkg::RST_FLAG;
        end else if (acc_load) begin
            acc_q       <= acc_value;
            parity_flag <= odd_ones(acc_value);
        end
    end
endmodule : psw_status_word

//--- sim/psw_status_word_properties.sv
/* psw_status_word_properties: port checker for the status word block.
   assumes: bound to psw_status_word, single clock hclk, async reset hresetn. */
`timescale 1ns/1ps
module psw_status_word_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        arith_valid,
    input wire logic [1:0]  arith_op,
    input wire logic        arith_excess,
    input wire logic        arith_nibble_carry,
    input wire logic        acc_load,
    input wire logic [7:0]  acc_value,
    input wire logic [2:0]  reg_index,
    input wire logic [4:0]  reg_addr,
    input wire logic [1:0]  bank_select,
    input wire logic        arith_excess_flag,
    input wire logic        nibble_carry_flag,
    input wire logic        parity_flag,
    input wire logic        user_flag_a,
    input wire logic        user_flag_b
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_q;
    // marks the data phase of a status word write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_q <= 1'b0;
        else wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:2] == 6'h00;
    end
    a_user_write: assert property (wr_q |=> {user_flag_a, user_flag_b} == $past({hwdata[5], hwdata[1]}))
        else $error("user flags not written");
    a_user_hold: assert property (!wr_q |=> $stable({user_flag_a, user_flag_b}))
        else $error("user flags changed without write");
    a_bank_write: assert property (wr_q |=> bank_select == $past(hwdata[4:3]))
        else $error("bank select not written");
    a_bank_addr: assert property (1'b1 |=> reg_addr == {$past(bank_select), $past(reg_index)})
        else $error("register address wrong");
    a_excess_set: assert property (arith_valid && arith_op != 2'h3 |=>
        arith_excess_flag == $past(arith_excess))
        else $error("excess flag wrong");
    a_excess_clear: assert property (arith_valid && arith_op == 2'h3 |=> !arith_excess_flag)
        else $error("excess flag not cleared");
    a_nibble_carry: assert property (arith_valid |=>
        nibble_carry_flag == ($past(arith_nibble_carry) && !$past(arith_op[1])))
        else $error("nibble carry wrong");
    a_parity_load: assert property (acc_load |=> parity_flag == ^$past(acc_value))
        else $error("parity wrong");
    a_parity_hold: assert property (!acc_load |=> $stable(parity_flag))
        else $error("parity changed without load");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or error");
    c_write: cover property (wr_q);
    c_op_other: cover property (arith_valid && arith_op == 2'h3 && arith_excess);
    c_odd_load: cover property (acc_load && ^acc_value);
endmodule : psw_status_word_properties
bind psw_status_word psw_status_word_properties psw_status_word_properties_i (.*);

//--- sim/psw_status_word_tb.sv
/* psw_status_word_tb: self-checking bench for the status word block.
   assumes: the bench is the only ahb-lite master and drives the datapath strobes. */
`timescale 1ns/1ps
module psw_status_word_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, arith_valid, arith_excess;
    logic        arith_nibble_carry, acc_load, arith_excess_flag, nibble_carry_flag, parity_flag;
    logic        user_flag_a, user_flag_b;
    logic [31:0] haddr, hwdata, hrdata, rd, r, exp_sw;
    logic [31:0] s = 32'h0000_974f;
    logic [7:0]  acc_value;
    logic [4:0]  reg_addr;
    logic [2:0]  reg_index, hsize = 3'h2;
    logic [1:0]  htrans, arith_op, bank_select;
    int          err_count, checked, cyc;
    psw_status_word psw_status_word_i (.*);
    assign hready = hreadyout;
    // clock and timeout
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one single ahb-lite transfer, read data left in rd
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hwdata <= ~d;
    endtask : xfer
    task automatic finish_test();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        {hsel, hwrite, arith_valid, arith_excess, arith_nibble_carry, acc_load} = 6'h00;
        {haddr, hwdata, acc_value, reg_index, htrans, arith_op} = '0;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(psw_pkg::ADDR_STATUS_WORD, 1'b0, 32'h0000_0000);
        chk(rd, psw_pkg::RDATA_ZERO);
        xfer(8'h0c, 1'b1, 32'hffff_ffff);
        xfer(8'h0c, 1'b0, 32'h0000_0000);
        chk(rd, psw_pkg::RDATA_ZERO);
        for (int b = 0; b < 4; b++) begin
            r = rnd();
            r[4:3] = b[1:0];
            exp_sw = {24'h00_0000, 1'b0, r[6:1], 1'b0};
            xfer(psw_pkg::ADDR_STATUS_WORD, 1'b1, r);
            xfer(psw_pkg::ADDR_STATUS_WORD, 1'b0, 32'h0000_0000);
            chk(rd, exp_sw);
            chk(bank_select, b[1:0]);
            xfer(psw_pkg::ADDR_BANK_BASE, 1'b1, rnd());
            xfer(psw_pkg::ADDR_BANK_BASE, 1'b0, 32'h0000_0000);
            chk(rd, {27'h000_0000, b[1:0], 3'h0});
            reg_index <= r[10:8];
            @(posedge hclk);
            #1 chk(reg_addr, {b[1:0], r[10:8]});
        end
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            r = (i == 0) ? 32'h0000_000f : rnd();
            @(posedge hclk);
            {arith_valid, arith_op, arith_excess, arith_nibble_carry} <= {1'b1, r[1:0], r[2], r[3]};
            @(posedge hclk);
            arith_valid <= 1'b0;
            exp_sw[2] = r[2] && r[1:0] != 2'h3;
            exp_sw[6] = r[3] && !r[1];
            #1 chk({nibble_carry_flag, arith_excess_flag}, {exp_sw[6], exp_sw[2]});
            chk({user_flag_a, user_flag_b}, {exp_sw[5], exp_sw[1]});
        end
        $display("test arithmetic done");
        for (int i = 0; i < 16; i++) begin
            r = (i == 0) ? 32'h0000_00ff : rnd();
            @(posedge hclk);
            acc_load <= 1'b1;
            acc_value <= r[7:0];
            @(posedge hclk);
            acc_load <= 1'b0;
            acc_value <= ~r[7:0];
            #1 chk(parity_flag, ^r[7:0]);
        end
        xfer(psw_pkg::ADDR_ACCUM, 1'b0, 32'h0000_0000);
        chk(rd, {24'h00_0000, r[7:0]});
        xfer(psw_pkg::ADDR_STATUS_WORD, 1'b0, 32'h0000_0000);
        chk(rd, exp_sw | (^r[7:0]));
        $display("test parity done");
        finish_test();
    end
endmodule : psw_status_word_tb
